/* File: host_port_pins.sv */
`timescale 1ns/1ps
`include "host_port_params.svh"

module host_port_pins #(
  parameter int FIFO_DEPTH = `RX_FIFO_DEPTH
) (
  input  wire logic                          mclk,
  input  wire logic                          rst_b,
  // Mode straps
  input  wire logic                          ext_interface_select,
  input  wire logic                          micro_mode_select,
  input  wire logic                          mux_mode_select,
  input  wire logic                          output_float_n,
  // Shared address pins
  input  wire logic [`HOST_ADDR_W-1:0]       host_addr_bus,
  output      logic [`HOST_ADDR_W-1:0]       mem_addr_pins,
  output      logic                          addr_pins_oe,
  // Shared data pins
  input  wire logic [`HOST_DATA_W-1:0]       host_data_bus,
  output      logic [`HOST_DATA_W-1:0]       data_pins_out,
  output      logic                          data_pins_oe,
  output      logic [`HOST_DATA_W-1:0]       data_hold_val,
  output      logic                          data_hold_en,
  // Shared control pins
  input  wire host_port_pkg::ctrl_pins_s     ctrl_pins_in,
  output      host_port_pkg::ctrl_pins_s     ctrl_pins_out,
  output      logic                          ctrl_pins_oe,
  output      logic                          host_ready,
  // Wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output      logic [31:0]                   wb_dat_o,
  output      logic                          wb_ack_o
);
  import host_port_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH + 1);

  generate
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256) begin : g_bad_depth
      $error("host_port_pins FIFO depth out of range");
    end
  endgenerate

  logic [`HOST_DATA_W-1:0] bank_switch_control_reg;
  logic [`HOST_DATA_W-1:0] host_control_reg;
  logic [`HOST_ADDR_W-1:0] host_address_reg;
  logic [`HOST_DATA_W-1:0] read_data_reg;
  logic [`HOST_ADDR_W-1:0] mem_addr_reg;
  logic                    overflow;

  logic                    host_mode;
  logic                    mux_mode;
  logic                    strobe;
  logic                    strobe_q;
  logic                    strobe_start;
  logic                    strobe_end;
  logic                    addr_strobe_q_n;
  logic                    addr_latch;
  xfer_state_e             xfer_state;
  logic                    xfer_read;
  reg_sel_e                xfer_sel;
  logic [`HOST_ADDR_W-1:0] xfer_addr;
  logic                    host_write;
  logic [`HOST_DATA_W-1:0] read_value;
  logic                    next_data_oe;

  rx_word_s                rx_in;
  rx_word_s                rx_out;
  logic                    rx_in_ready;
  logic                    rx_out_valid;
  logic                    rx_pop;
  logic [CW-1:0]           rx_count;

  logic                    wb_req;
  logic                    wb_wr;
  logic                    wb_rd;
  logic [31:0]             next_wb_dat;

  // Pin ownership
  assign host_mode = !ext_interface_select && !micro_mode_select;
  assign mux_mode  = !mux_mode_select;

  // Either data strobe low, with chip select low, frames a transfer
  assign strobe = host_mode && !ctrl_pins_in.port_select_n &&
                  (!ctrl_pins_in.data_strobe_1_n || !ctrl_pins_in.data_strobe_2_n);
  assign strobe_start = strobe && !strobe_q;
  assign strobe_end   = !strobe && strobe_q;

  // Address strobe falling edge, only honoured in mux mode
  assign addr_latch = host_mode && mux_mode && !ctrl_pins_in.addr_strobe_n &&
                      addr_strobe_q_n;

  assign host_write = strobe_end && (xfer_state == XFER_ACTIVE) && !xfer_read;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_q        <= 1'b0;
      addr_strobe_q_n <= 1'b1;
    end else begin
      strobe_q        <= strobe;
      addr_strobe_q_n <= ctrl_pins_in.addr_strobe_n;
    end
  end

  // Transfer capture: direction, select and address are taken at strobe start
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      xfer_state <= XFER_IDLE;
      xfer_read  <= 1'b0;
      xfer_sel   <= SEL_CONTROL;
      xfer_addr  <= '0;
    end else begin
      unique case (xfer_state)
        XFER_IDLE: begin
          if (strobe_start) begin
            xfer_state <= XFER_ACTIVE;
            xfer_read  <= ctrl_pins_in.read_not_write;
            if (mux_mode) begin
              xfer_sel  <= reg_sel_e'(ctrl_pins_in.reg_select);
              xfer_addr <= host_address_reg;
            end else begin
              xfer_sel  <= SEL_DATA;
              xfer_addr <= host_addr_bus;
            end
          end
        end
        XFER_ACTIVE: begin
          if (strobe_end) begin
            xfer_state <= XFER_IDLE;
          end
        end
      endcase
    end
  end

  // Host view of the selected register
  always_comb begin
    read_value = read_data_reg;
    if (mux_mode) begin
      unique case (reg_sel_e'(ctrl_pins_in.reg_select))
        SEL_CONTROL:  read_value = host_control_reg;
        SEL_ADDRESS:  read_value = host_address_reg[`HOST_DATA_W-1:0];
        SEL_DATA_INC,
        SEL_DATA:     read_value = read_data_reg;
      endcase
    end
  end

  // Host control register: written by the host through the control select
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      host_control_reg <= `RST_HOST_CONTROL;
    end else if (host_write && mux_mode && xfer_sel == SEL_CONTROL) begin
      host_control_reg <= host_data_bus;
    end
  end

  // Host address register: address strobe latch, host write, auto-increment
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      host_address_reg <= `RST_HOST_ADDRESS;
    end else if (addr_latch) begin
      host_address_reg <= {{(`HOST_ADDR_W-`HOST_DATA_W){1'b0}}, host_data_bus};
    end else if (host_write && mux_mode && xfer_sel == SEL_ADDRESS) begin
      host_address_reg <= {{(`HOST_ADDR_W-`HOST_DATA_W){1'b0}}, host_data_bus};
    end else if (strobe_end && mux_mode && xfer_sel == SEL_DATA_INC) begin
      host_address_reg <= host_address_reg + 1'b1;
    end
  end

  // Data writes enter the receive FIFO
  assign rx_in.addr = xfer_addr;
  assign rx_in.data = host_data_bus;

  host_port_fifo #(
    .WIDTH ($bits(rx_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_data   (rx_in),
    .in_valid  (host_write && (xfer_sel == SEL_DATA || xfer_sel == SEL_DATA_INC)),
    .in_ready  (rx_in_ready),
    .out_data  (rx_out),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .count     (rx_count)
  );

  // Data bus direction
  assign next_data_oe = output_float_n && host_mode && strobe &&
                        ctrl_pins_in.read_not_write;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      data_pins_oe  <= 1'b0;
      data_pins_out <= '0;
    end else begin
      data_pins_oe <= next_data_oe;
      if (strobe_start && ctrl_pins_in.read_not_write) begin
        data_pins_out <= read_value;
      end
    end
  end

  // Bus holders keep the last level the host left on the data pins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      data_hold_en  <= 1'b0;
      data_hold_val <= '0;
    end else begin
      data_hold_en <= output_float_n && host_mode && mux_mode && !next_data_oe &&
                      bank_switch_control_reg[`BIT_HOLDER_ENABLE];
      if (!data_pins_oe) begin
        data_hold_val <= host_data_bus;
      end
    end
  end

  // Memory-side ownership of the shared address and control pins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_pins_oe  <= 1'b0;
      mem_addr_pins <= '0;
      ctrl_pins_oe  <= 1'b0;
      ctrl_pins_out <= '1;
      host_ready    <= 1'b0;
    end else begin
      addr_pins_oe  <= output_float_n && !host_mode;
      mem_addr_pins <= mem_addr_reg;
      ctrl_pins_oe  <= output_float_n && !host_mode;
      ctrl_pins_out <= '1;
      host_ready    <= host_mode && rx_in_ready;
    end
  end

  // Overflow: a host data write met a full FIFO; set wins over clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      overflow <= 1'b0;
    end else if (host_write && !rx_in_ready &&
                 (xfer_sel == SEL_DATA || xfer_sel == SEL_DATA_INC)) begin
      overflow <= 1'b1;
    end else if (wb_wr && wb_adr_i == `OFS_PORT_STATUS && wb_sel_i[0] &&
                 wb_dat_i[`BIT_STAT_OVERFLOW]) begin
      overflow <= 1'b0;
    end
  end

  // Wishbone slave, one wait state
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i;
  assign wb_rd  = wb_req && !wb_we_i;
  assign rx_pop = wb_rd && wb_adr_i == `OFS_RX_DATA && rx_out_valid;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bank_switch_control_reg <= `RST_BANK_SWITCH_CTRL;
      read_data_reg           <= `RST_READ_DATA;
      mem_addr_reg            <= `RST_MEM_ADDR;
    end else if (wb_wr) begin
      unique case (wb_adr_i)
        `OFS_BANK_SWITCH_CTRL: begin
          if (wb_sel_i[0]) bank_switch_control_reg[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) bank_switch_control_reg[15:8] <= wb_dat_i[15:8];
        end
        `OFS_READ_DATA: begin
          if (wb_sel_i[0]) read_data_reg[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) read_data_reg[15:8] <= wb_dat_i[15:8];
        end
        `OFS_MEM_ADDR: begin
          if (wb_sel_i[0]) mem_addr_reg[7:0]   <= wb_dat_i[7:0];
          if (wb_sel_i[1]) mem_addr_reg[15:8]  <= wb_dat_i[15:8];
          if (wb_sel_i[2]) mem_addr_reg[17:16] <= wb_dat_i[17:16];
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    next_wb_dat = 32'h0000_0000;
    unique case (wb_adr_i)
      `OFS_BANK_SWITCH_CTRL: next_wb_dat[15:0] = bank_switch_control_reg;
      `OFS_PORT_STATUS: begin
        next_wb_dat[`BIT_STAT_HOST_MODE] = host_mode;
        next_wb_dat[`BIT_STAT_RX_VALID]  = rx_out_valid;
        next_wb_dat[`BIT_STAT_OVERFLOW]  = overflow;
        next_wb_dat[`BIT_STAT_MUX_MODE]  = mux_mode;
        next_wb_dat[`POS_STAT_COUNT +: CW] = rx_count;
      end
      `OFS_RX_DATA:      next_wb_dat[15:0] = rx_out_valid ? rx_out.data : 16'h0000;
      `OFS_RX_ADDR:      next_wb_dat[17:0] = rx_out_valid ? rx_out.addr : 18'h0_0000;
      `OFS_READ_DATA:    next_wb_dat[15:0] = read_data_reg;
      `OFS_HOST_CONTROL: next_wb_dat[15:0] = host_control_reg;
      `OFS_HOST_ADDRESS: next_wb_dat[17:0] = host_address_reg;
      `OFS_MEM_ADDR:     next_wb_dat[17:0] = mem_addr_reg;
      default:           next_wb_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_rd) begin
        wb_dat_o <= next_wb_dat;
      end
    end
  end

endmodule // host_port_pins

/* File: host_port_params.svh */
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

// Register offsets, byte addresses on the Wishbone slave
`define OFS_BANK_SWITCH_CTRL 8'h00
`define OFS_PORT_STATUS      8'h04
`define OFS_RX_DATA          8'h08
`define OFS_RX_ADDR          8'h0C
`define OFS_READ_DATA        8'h10
`define OFS_HOST_CONTROL     8'h14
`define OFS_HOST_ADDRESS     8'h18
`define OFS_MEM_ADDR         8'h1C

// Field positions
`define BIT_HOLDER_ENABLE    0
`define BIT_STAT_HOST_MODE   0
`define BIT_STAT_RX_VALID    1
`define BIT_STAT_OVERFLOW    2
`define BIT_STAT_MUX_MODE    3
`define POS_STAT_COUNT       8

// Reset values
`define RST_BANK_SWITCH_CTRL 16'h0000
`define RST_HOST_CONTROL     16'h0000
`define RST_HOST_ADDRESS     18'h0_0000
`define RST_READ_DATA        16'h0000
`define RST_MEM_ADDR         18'h0_0000

// Widths and depths
`define HOST_ADDR_W          18
`define HOST_DATA_W          16
`define RX_FIFO_DEPTH        16

`endif

/* File: host_port_pkg.sv */
`include "host_port_params.svh"

package host_port_pkg;

  // Shared control pins: register selects, address strobe, chip select, data strobes, direction
  typedef struct packed {
    logic [1:0] reg_select;
    logic       addr_strobe_n;
    logic       port_select_n;
    logic       data_strobe_1_n;
    logic       data_strobe_2_n;
    logic       read_not_write;
  } ctrl_pins_s;

  // One host write as it enters the receive FIFO
  typedef struct packed {
    logic [`HOST_ADDR_W-1:0] addr;
    logic [`HOST_DATA_W-1:0] data;
  } rx_word_s;

  // Register chosen by the two select inputs
  typedef enum logic [1:0] {
    SEL_CONTROL   = 2'h0,
    SEL_DATA_INC  = 2'h1,
    SEL_ADDRESS   = 2'h2,
    SEL_DATA      = 2'h3
  } reg_sel_e;

  typedef enum logic {
    XFER_IDLE,
    XFER_ACTIVE
  } xfer_state_e;

endpackage

/* File: host_port_fifo.sv */
`timescale 1ns/1ps

module host_port_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  input  wire logic [WIDTH-1:0]           in_data,
  input  wire logic                       in_valid,
  output      logic                       in_ready,
  output      logic [WIDTH-1:0]           out_data,
  output      logic                       out_valid,
  input  wire logic                       out_ready,
  output      logic [$clog2(DEPTH+1)-1:0] count
);

  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("host_port_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (count != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // host_port_fifo

/* File: host_port_chk_sva.sv */
`timescale 1ns/1ps
`include "host_port_params.svh"

module host_port_chk (
  input wire logic                     mclk,
  input wire logic                     rst_b,
  input wire logic                     ext_interface_select,
  input wire logic                     micro_mode_select,
  input wire logic                     mux_mode_select,
  input wire logic                     output_float_n,
  input wire logic                     addr_pins_oe,
  input wire logic                     data_pins_oe,
  input wire logic                     ctrl_pins_oe,
  input wire logic                     data_hold_en,
  input wire logic [`HOST_DATA_W-1:0]  data_hold_val,
  input wire logic [`HOST_DATA_W-1:0]  host_data_bus,
  input wire host_port_pkg::ctrl_pins_s ctrl_pins_in,
  input wire logic                     host_ready,
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_ack_o
);
  import host_port_pkg::*;
  logic host_m;
  logic strb;
  assign host_m = !ext_interface_select && !micro_mode_select;
  assign strb = host_m && !ctrl_pins_in.port_select_n
                && (!ctrl_pins_in.data_strobe_1_n || !ctrl_pins_in.data_strobe_2_n);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  float_off_a: assert property (!output_float_n |=> !addr_pins_oe && !data_pins_oe
    && !ctrl_pins_oe && !data_hold_en) else $error("pins driven while floated");
  host_release_a: assert property (host_m |=> !addr_pins_oe && !ctrl_pins_oe)
    else $error("memory pins driven in host mode");
  mem_drive_a: assert property (output_float_n && !host_m |=> addr_pins_oe && ctrl_pins_oe)
    else $error("memory pins not driven outside host mode");
  read_drive_a: assert property (data_pins_oe |->
    $past(strb && ctrl_pins_in.read_not_write && output_float_n))
    else $error("data bus driven without a host read");
  write_quiet_a: assert property (strb && !ctrl_pins_in.read_not_write ##1 strb
    |-> !data_pins_oe) else $error("data bus driven during a host write");
  holder_mode_a: assert property (data_hold_en |->
    $past(!mux_mode_select && host_m && output_float_n))
    else $error("holder active outside mux host mode");
  holder_track_a: assert property (data_hold_en |-> data_hold_val == $past(host_data_bus))
    else $error("holder lost the last bus level");
  ready_mode_a: assert property (host_ready |-> $past(host_m))
    else $error("ready outside host mode");
  ack_once_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge not a single pulse");

  cover property (data_pins_oe ##1 !data_pins_oe);
  cover property (data_hold_en [*3]);
  cover property (host_m && !host_ready);
endmodule // host_port_chk

/* File: host_model.sv */
`timescale 1ns/1ps
`include "host_port_params.svh"

module host_model (
  input  wire logic                     mclk,
  input  wire logic [`HOST_DATA_W-1:0]  data_pins_out,
  input  wire logic                     data_pins_oe,
  input  wire logic [`HOST_DATA_W-1:0]  data_hold_val,
  input  wire logic                     data_hold_en,
  output      host_port_pkg::ctrl_pins_s ctrl,
  output      logic [`HOST_ADDR_W-1:0]  host_addr_bus,
  output wire logic [`HOST_DATA_W-1:0]  host_data_bus
);
  import host_port_pkg::*;
  logic                    drv_en = 1'b0;
  logic [`HOST_DATA_W-1:0] drv_val = 16'h0000;
  logic [`HOST_DATA_W-1:0] last = 16'h0000;

  initial begin
    ctrl = '1;
    ctrl.read_not_write = 1'b0;
    host_addr_bus = 18'h0_0000;
  end

  // Released bus shows the holder, else the inverse of the last level
  assign host_data_bus = data_pins_oe ? data_pins_out : drv_en ? drv_val :
                         data_hold_en ? data_hold_val : ~last;

  always @(posedge mclk) begin
    if (drv_en) last <= drv_val;
  end

  task automatic xfer(input logic rw, input logic [1:0] sel, input logic [17:0] a,
                      input logic [15:0] d, input logic use2, output logic [15:0] q);
    @(posedge mclk);
    ctrl.port_select_n <= 1'b0;
    if (use2) ctrl.data_strobe_2_n <= 1'b0;
    else ctrl.data_strobe_1_n <= 1'b0;
    ctrl.read_not_write <= rw;
    ctrl.reg_select <= sel;
    host_addr_bus <= a;
    drv_en <= !rw;
    drv_val <= d;
    repeat (3) @(posedge mclk);
    q = host_data_bus;
    ctrl.data_strobe_1_n <= 1'b1;
    ctrl.data_strobe_2_n <= 1'b1;
    @(posedge mclk);
    drv_en <= 1'b0;
    ctrl.port_select_n <= 1'b1;
    @(posedge mclk);
  endtask

  task automatic astrobe(input logic [15:0] d);
    @(posedge mclk);
    drv_en <= 1'b1;
    drv_val <= d;
    @(posedge mclk);
    ctrl.addr_strobe_n <= 1'b0;
    repeat (2) @(posedge mclk);
    ctrl.addr_strobe_n <= 1'b1;
    drv_en <= 1'b0;
    @(posedge mclk);
  endtask
endmodule // host_model

/* File: tb.sv */
`timescale 1ns/1ps

module tb;
  import host_port_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        xsel = 1'b1;
  logic        msel = 1'b0;
  logic        mux = 1'b1;
  logic        flt_n = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [17:0] haddr, maddr;
  logic [15:0] hdata, dout, hval, q;
  ctrl_pins_s  cin, cout;
  logic        aoe, doe, hen, coe, rdy, ack;
  logic [31:0] rdat, r;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #4 mclk = ~mclk;

  host_port_pins i_dut (.mclk(mclk), .rst_b(rst_b), .ext_interface_select(xsel),
    .micro_mode_select(msel), .mux_mode_select(mux), .output_float_n(flt_n),
    .host_addr_bus(haddr), .mem_addr_pins(maddr), .addr_pins_oe(aoe), .host_data_bus(hdata),
    .data_pins_out(dout), .data_pins_oe(doe), .data_hold_val(hval), .data_hold_en(hen),
    .ctrl_pins_in(cin), .ctrl_pins_out(cout), .ctrl_pins_oe(coe), .host_ready(rdy),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

  host_model i_host (.mclk(mclk), .data_pins_out(dout), .data_pins_oe(doe),
    .data_hold_val(hval), .data_hold_en(hen), .ctrl(cin), .host_addr_bus(haddr),
    .host_data_bus(hdata));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] qd);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    qd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic set_mode(input logic x, input logic m, input logic mx);
    @(posedge mclk);
    xsel <= x;
    msel <= m;
    mux <= mx;
    repeat (2) @(posedge mclk);
  endtask

  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      set_mode(i[1], i[0], 1'b1);
      chk("addr_oe", {31'h0, i != 0}, {31'h0, aoe});
      chk("ctrl_oe", {31'h0, i != 0}, {31'h0, coe});
      chk("ready", {31'h0, i == 0}, {31'h0, rdy});
    end
    flt_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("float_oe", 32'h0, {29'h0, aoe, coe, doe});
    flt_n <= 1'b1;
    wb(1'b1, 8'h1C, 32'h0002_5A5A, r);
    @(posedge mclk);
    chk("mem_addr", 32'h0002_5A5A, {14'h0, maddr});
    chk("ctrl_idle", 32'h0000_007F, {25'h0, cout});
    wb(1'b0, 8'h1C, 32'h0, r);
    chk("mem_addr_reg", 32'h0002_5A5A, r);
  endtask

  task automatic t_nonmux;
    set_mode(1'b0, 1'b0, 1'b1);
    wb(1'b0, 8'h00, 32'h0, r);
    chk("holder_bit", 32'h0, r);
    i_host.astrobe(16'h0F0F);
    wb(1'b0, 8'h18, 32'h0, r);
    chk("addr_reg", 32'h0, r);
    i_host.xfer(1'b0, 2'h1, 18'h2_A5C3, 16'h1357, 1'b1, q);
    wb(1'b0, 8'h0C, 32'h0, r);
    chk("rx_addr", 32'h0002_A5C3, r);
    wb(1'b0, 8'h08, 32'h0, r);
    chk("rx_data", 32'h0000_1357, r);
    wb(1'b1, 8'h10, 32'h0000_C0DE, r);
    for (int i = 0; i < 2; i++) begin
      i_host.xfer(1'b1, 2'h3, 18'h0_0010, 16'h0000, i[0], q);
      chk("host_read", 32'h0000_C0DE, {16'h0, q});
    end
  endtask

  task automatic t_mux;
    set_mode(1'b0, 1'b0, 1'b0);
    i_host.astrobe(16'h4321);
    wb(1'b0, 8'h18, 32'h0, r);
    chk("addr_latch", 32'h0000_4321, r);
    i_host.xfer(1'b0, SEL_DATA, 18'h3_FFFF, 16'h55AA, 1'b0, q);
    wb(1'b0, 8'h0C, 32'h0, r);
    chk("mux_addr", 32'h0000_4321, r);
    wb(1'b0, 8'h08, 32'h0, r);
    chk("mux_data", 32'h0000_55AA, r);
    i_host.xfer(1'b0, SEL_DATA_INC, 18'h3_FFFF, 16'h1111, 1'b0, q);
    wb(1'b0, 8'h18, 32'h0, r);
    chk("addr_inc", 32'h0000_4322, r);
    i_host.xfer(1'b0, SEL_CONTROL, 18'h0_0000, 16'h0001, 1'b0, q);
    wb(1'b0, 8'h14, 32'h0, r);
    chk("control_reg", 32'h0000_0001, r);
    i_host.xfer(1'b1, SEL_CONTROL, 18'h0_0000, 16'h0000, 1'b1, q);
    chk("mux_rd_ctrl", 32'h0000_0001, {16'h0, q});
    chk("rd_oe_off", 32'h0, {31'h0, doe});
    i_host.xfer(1'b0, SEL_ADDRESS, 18'h0_0000, 16'h0777, 1'b0, q);
    i_host.xfer(1'b1, SEL_ADDRESS, 18'h0_0000, 16'h0000, 1'b0, q);
    chk("mux_rd_addr", 32'h0000_0777, {16'h0, q});
    chk("holder_off", 32'h0, {31'h0, hen});
    wb(1'b1, 8'h00, 32'h0000_0001, r);
    i_host.astrobe(16'hBEEF);
    repeat (3) @(posedge mclk);
    chk("holder_on", 32'h1, {31'h0, hen});
    chk("held_bus", 32'h0000_BEEF, {16'h0, hdata});
    chk("held_val", 32'h0000_BEEF, {16'h0, hval});
    wb(1'b1, 8'h00, 32'h0, r);
    repeat (2) @(posedge mclk);
    chk("holder_cleared", 32'h0, {31'h0, hen});
  endtask

  task automatic t_fifo;
    set_mode(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 20; i++) begin
      wb(1'b0, 8'h04, 32'h0, r);
      if (r[1]) wb(1'b0, 8'h08, 32'h0, r);
    end
    for (int i = 0; i < 17; i++)
      i_host.xfer(1'b0, 2'h0, 18'(i), 16'hA000 + 16'(i), 1'b0, q);
    chk("full_ready", 32'h0, {31'h0, rdy});
    wb(1'b0, 8'h04, 32'h0, r);
    chk("count", 32'h10, {27'h0, r[12:8]});
    chk("overflow", 32'h1, {31'h0, r[2]});
    wb(1'b1, 8'h04, 32'h0000_0004, r);
    for (int i = 0; i < 16; i++) begin
      wb(1'b0, 8'h08, 32'h0, r);
      chk("drain", 32'h0000_A000 + i, r);
    end
    wb(1'b0, 8'h04, 32'h0, r);
    chk("empty", 32'h0, {29'h0, r[2:0]} & 32'h6);
    chk("ready_back", 32'h1, {31'h0, rdy});
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    t_modes();
    t_nonmux();
    t_mux();
    t_fifo();
    end_sim();
  end
endmodule // tb

bind host_port_pins host_port_chk u_chk (.mclk(mclk), .rst_b(rst_b),
  .ext_interface_select(ext_interface_select), .micro_mode_select(micro_mode_select),
  .mux_mode_select(mux_mode_select), .output_float_n(output_float_n),
  .addr_pins_oe(addr_pins_oe), .data_pins_oe(data_pins_oe), .ctrl_pins_oe(ctrl_pins_oe),
  .data_hold_en(data_hold_en), .data_hold_val(data_hold_val), .host_data_bus(host_data_bus),
  .ctrl_pins_in(ctrl_pins_in), .host_ready(host_ready), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
